/* verilog/sfc_pkg.sv */
package sfc_pkg;
    // Register addresses on the serial port
    localparam logic [6:0] ADDR_RATE_HIGH = 7'h6e;
    localparam logic [6:0] ADDR_RATE_LOW = 7'h6f;
    localparam logic [6:0] ADDR_RATE_SCALE = 7'h70;
    localparam logic [6:0] ADDR_MOD_CTRL = 7'h71;
    localparam logic [6:0] ADDR_DEV_LOW = 7'h72;
    localparam logic [6:0] ADDR_OFS_LOW = 7'h73;
    localparam logic [6:0] ADDR_OFS_HIGH = 7'h74;
    localparam logic [6:0] ADDR_BAND = 7'h75;
    localparam logic [6:0] ADDR_NOM_HIGH = 7'h76;
    localparam logic [6:0] ADDR_NOM_LOW = 7'h77;
    localparam logic [6:0] ADDR_HOP_CHAN = 7'h79;
    localparam logic [6:0] ADDR_HOP_STEP = 7'h7a;
    // Values after reset
    localparam logic [7:0] RST_RATE_HIGH = 8'h0a;
    localparam logic [7:0] RST_RATE_LOW = 8'haa;
    localparam logic [7:0] RST_RATE_SCALE = 8'h00;
    localparam logic [7:0] RST_MOD_CTRL = 8'h00;
    localparam logic [7:0] RST_DEV_LOW = 8'h43;
    localparam logic [7:0] RST_OFS = 8'h00;
    localparam logic [7:0] RST_BAND = 8'h35;
    localparam logic [7:0] RST_NOM_HIGH = 8'hbb;
    localparam logic [7:0] RST_NOM_LOW = 8'h80;
    localparam logic [7:0] RST_HOP = 8'h00;
    // Field positions and writable masks
    localparam int BAND_HIGH_BIT = 5;
    localparam int DEV_MSB_BIT = 2;
    localparam int RATE_SCALE_BIT = 0;
    localparam logic [7:0] MASK_BAND = 8'h7f;
    localparam logic [7:0] MASK_OFS_HIGH = 8'h03;
    localparam logic [7:0] MASK_RATE_SCALE = 8'h01;
    // Divider arithmetic
    localparam logic [4:0] BAND_INT_MAX = 5'h17;
    localparam logic [6:0] BAND_INT_BASE = 7'h18;
    localparam logic [23:0] FRAC_MODULUS = 24'h00fa00;
    // Frequencies in centihertz; one fraction step is 156.25 Hz per band factor
    localparam int FRAC_LSB_CHZ = 15625;
    localparam int IF_SHIFT_CHZ = 93750000;
    localparam int HOP_LSB_CHZ = 1000000;
    localparam int DEV_LSB_CHZ = 62500;
    localparam int IF_UNITS = IF_SHIFT_CHZ / FRAC_LSB_CHZ;
    localparam int HOP_UNITS = HOP_LSB_CHZ / FRAC_LSB_CHZ;
    localparam int DEV_UNITS = DEV_LSB_CHZ / FRAC_LSB_CHZ;
    // Bit rate generator
    localparam int CLK_HZ = 20000000;
    localparam int RATE_REF_HZ = 1000000;
    localparam int RATE_PRESCALE = CLK_HZ / RATE_REF_HZ;
    localparam int RATE_EXP_BASE = 16;
    localparam int RATE_EXP_STEP = 5;
    // Modulation type field
    typedef enum logic [1:0] {
        MOD_CARRIER = 2'b00,
        MOD_OOK = 2'b01,
        MOD_FSK = 2'b10,
        MOD_GFSK = 2'b11
    } sfc_mod_e;
endpackage : sfc_pkg

/* verilog/sfc_divmod.sv */
module sfc_divmod (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [23:0] total,
    output logic [6:0] div_int,
    output logic [15:0] div_frac
);
    logic [23:0] quot;
    logic [23:0] rem;

    // Split total fraction steps into integer and modulus remainder
    assign quot = total / sfc_pkg::FRAC_MODULUS;
    assign rem = total - quot * sfc_pkg::FRAC_MODULUS;

    // Registered so the wide divide has a full cycle
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            div_int <= 7'h00;
            div_frac <= 16'h0000;
        end
        else
        begin
            div_int <= quot[6:0];
            div_frac <= rem[15:0];
        end
    end

    property p_frac_range;
        @(posedge core_clk) disable iff (srst)
        div_frac < sfc_pkg::FRAC_MODULUS[15:0];
    endproperty
    a_frac_range: assert property (p_frac_range) else $error("fraction not below modulus");
endmodule : sfc_divmod

/* verilog/sfc_spi_slave.sv */
module sfc_spi_slave (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic spi_sck,
    input wire logic spi_nsel,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    output logic [6:0] rd_addr,
    input wire logic [7:0] rd_data,
    output logic wr_stb,
    output logic [6:0] wr_addr,
    output logic [7:0] wr_data
);
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_f;
    logic sck_prev;
    logic sck_rise;
    logic sck_fall;
    logic [3:0] bit_cnt;
    logic [6:0] shift_in;
    logic is_write;
    logic load_pend;
    logic [7:0] out_sh;
    logic [7:0] rx_byte;

    // Three-stage synchronisers; bit 2 sck, bit 1 select, bit 0 data
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pin_s1 <= 3'h2;
            pin_s2 <= 3'h2;
            pin_s3 <= 3'h2;
        end
        else
        begin
            pin_s1 <= {spi_sck, spi_nsel, spi_sdi};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // A change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_filt
            always_ff @(posedge core_clk)
            begin
                if (srst)
                    pin_f[gi] <= (gi == 1);
                else if (pin_s2[gi] == pin_s3[gi])
                    pin_f[gi] <= pin_s3[gi];
            end
        end
    endgenerate

    assign sck_rise = pin_f[2] && !sck_prev;
    assign sck_fall = !pin_f[2] && sck_prev;
    assign rx_byte = {shift_in, pin_f[0]};

    // Command byte, data bytes and burst address increment
    always_ff @(posedge core_clk)
    begin
        if (srst || pin_f[1])
        begin
            sck_prev <= pin_f[2] && !srst;
            bit_cnt <= 4'h0;
            shift_in <= 7'h00;
            is_write <= 1'b0;
            load_pend <= 1'b0;
            rd_addr <= 7'h00;
            wr_stb <= 1'b0;
            wr_addr <= 7'h00;
            wr_data <= 8'h00;
        end
        else
        begin
            sck_prev <= pin_f[2];
            wr_stb <= 1'b0;
            load_pend <= 1'b0;
            if (sck_rise)
            begin
                shift_in <= rx_byte[6:0];
                bit_cnt <= (bit_cnt == 4'hf) ? 4'h8 : bit_cnt + 4'h1;
                if (bit_cnt == 4'h7)
                begin
                    is_write <= rx_byte[7];
                    rd_addr <= rx_byte[6:0];
                    load_pend <= !rx_byte[7];
                end
                else if (bit_cnt == 4'hf)
                begin
                    wr_stb <= is_write;
                    wr_addr <= rd_addr;
                    wr_data <= rx_byte;
                    rd_addr <= rd_addr + 7'h01;
                    load_pend <= !is_write;
                end
            end
        end
    end

    // Read data changes on falling sck; first bit is set up before it
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            spi_sdo <= 1'b0;
            spi_sdo_oe <= 1'b0;
            out_sh <= 8'h00;
        end
        else
        begin
            spi_sdo_oe <= !pin_f[1];
            if (load_pend)
            begin
                spi_sdo <= rd_data[7];
                out_sh <= {rd_data[6:0], 1'b0};
            end
            else if (sck_fall && !is_write && bit_cnt > 4'h8)
            begin
                spi_sdo <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
        end
    end
endmodule : sfc_spi_slave

/* verilog/sfc_freq_ctrl.sv */
module sfc_freq_ctrl #(
    parameter int RATE_PRESCALE = sfc_pkg::RATE_PRESCALE
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic spi_sck,
    input wire logic spi_nsel,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic tx_active,
    input wire logic tx_data_bit,
    output logic [6:0] div_int,
    output logic [15:0] div_frac,
    output logic band_high,
    output logic retune_req,
    output logic bit_tick
);
    logic [7:0] data_rate_high;
    logic [7:0] data_rate_low;
    logic [7:0] rate_scale_reg;
    logic [7:0] modulation_control_two;
    logic [7:0] deviation_low_byte;
    logic [7:0] offset_low_byte;
    logic [7:0] offset_high_bits;
    logic [7:0] band_select;
    logic [7:0] nominal_carrier_high;
    logic [7:0] nominal_carrier_low;
    logic [7:0] hop_channel_select;
    logic [7:0] hop_step_size;
    logic wr_stb;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic [15:0] carrier_fraction;
    logic [9:0] fine_offset_word;
    logic [8:0] deviation_word;
    logic [4:0] band_integer;
    logic [15:0] txdr;
    logic rate_scale;
    logic fsk_on;
    logic [6:0] n_int;
    logic [23:0] int_units;
    logic [23:0] hop_units;
    logic [23:0] off_units;
    logic [23:0] if_units;
    logic [23:0] dev_units;
    logic [23:0] next_base_total;
    logic [23:0] next_dev_term;
    logic [23:0] base_total;
    logic [23:0] dev_term;
    logic [23:0] synth_total;
    logic [4:0] presc_cnt;
    logic presc_wrap;
    logic [20:0] rate_acc;
    logic [21:0] rate_sum;

    ////////////////////////////////////////////////////////////////////////
    // Serial register port

    sfc_spi_slave u_spi (
        .core_clk(core_clk),
        .srst(srst),
        .spi_sck(spi_sck),
        .spi_nsel(spi_nsel),
        .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .wr_stb(wr_stb),
        .wr_addr(wr_addr),
        .wr_data(wr_data)
    );

    // Band integer above the top band is stored as the top band
    function automatic logic [4:0] clamp_band(input logic [4:0] v);
        clamp_band = (v > sfc_pkg::BAND_INT_MAX) ? sfc_pkg::BAND_INT_MAX : v;
    endfunction : clamp_band

    // Read mux; unmapped addresses and reserved bits read zero
    function automatic logic [7:0] reg_read(input logic [6:0] a);
        case (a)
            sfc_pkg::ADDR_RATE_HIGH: reg_read = data_rate_high;
            sfc_pkg::ADDR_RATE_LOW: reg_read = data_rate_low;
            sfc_pkg::ADDR_RATE_SCALE: reg_read = rate_scale_reg;
            sfc_pkg::ADDR_MOD_CTRL: reg_read = modulation_control_two;
            sfc_pkg::ADDR_DEV_LOW: reg_read = deviation_low_byte;
            sfc_pkg::ADDR_OFS_LOW: reg_read = offset_low_byte;
            sfc_pkg::ADDR_OFS_HIGH: reg_read = offset_high_bits;
            sfc_pkg::ADDR_BAND: reg_read = band_select;
            sfc_pkg::ADDR_NOM_HIGH: reg_read = nominal_carrier_high;
            sfc_pkg::ADDR_NOM_LOW: reg_read = nominal_carrier_low;
            sfc_pkg::ADDR_HOP_CHAN: reg_read = hop_channel_select;
            sfc_pkg::ADDR_HOP_STEP: reg_read = hop_step_size;
            default: reg_read = 8'h00;
        endcase
    endfunction : reg_read

    always_comb // A process, so register writes also re-run the mux, not only address changes
        rd_data = reg_read(rd_addr);

    ////////////////////////////////////////////////////////////////////////
    // Register bank

    // Data rate and modulation registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            data_rate_high <= sfc_pkg::RST_RATE_HIGH;
            data_rate_low <= sfc_pkg::RST_RATE_LOW;
            rate_scale_reg <= sfc_pkg::RST_RATE_SCALE;
            modulation_control_two <= sfc_pkg::RST_MOD_CTRL;
            deviation_low_byte <= sfc_pkg::RST_DEV_LOW;
        end
        else if (wr_stb)
        begin
            case (wr_addr)
                sfc_pkg::ADDR_RATE_HIGH: data_rate_high <= wr_data;
                sfc_pkg::ADDR_RATE_LOW: data_rate_low <= wr_data;
                sfc_pkg::ADDR_RATE_SCALE: rate_scale_reg <= wr_data & sfc_pkg::MASK_RATE_SCALE;
                sfc_pkg::ADDR_MOD_CTRL: modulation_control_two <= wr_data;
                sfc_pkg::ADDR_DEV_LOW: deviation_low_byte <= wr_data;
                default: ;
            endcase
        end
    end

    // Carrier, offset and hop registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            offset_low_byte <= sfc_pkg::RST_OFS;
            offset_high_bits <= sfc_pkg::RST_OFS;
            band_select <= sfc_pkg::RST_BAND;
            nominal_carrier_high <= sfc_pkg::RST_NOM_HIGH;
            nominal_carrier_low <= sfc_pkg::RST_NOM_LOW;
            hop_channel_select <= sfc_pkg::RST_HOP;
            hop_step_size <= sfc_pkg::RST_HOP;
        end
        else if (wr_stb)
        begin
            case (wr_addr)
                sfc_pkg::ADDR_OFS_LOW: offset_low_byte <= wr_data;
                sfc_pkg::ADDR_OFS_HIGH: offset_high_bits <= wr_data & sfc_pkg::MASK_OFS_HIGH;
                sfc_pkg::ADDR_BAND:
                    band_select <= {wr_data[7:5] & sfc_pkg::MASK_BAND[7:5], clamp_band(wr_data[4:0])};
                sfc_pkg::ADDR_NOM_HIGH: nominal_carrier_high <= wr_data;
                sfc_pkg::ADDR_NOM_LOW: nominal_carrier_low <= wr_data;
                sfc_pkg::ADDR_HOP_CHAN: hop_channel_select <= wr_data;
                sfc_pkg::ADDR_HOP_STEP: hop_step_size <= wr_data;
                default: ;
            endcase
        end
    end

    // Field views of the bank
    assign carrier_fraction = {nominal_carrier_high, nominal_carrier_low};
    assign fine_offset_word = {offset_high_bits[1:0], offset_low_byte};
    assign deviation_word = {modulation_control_two[sfc_pkg::DEV_MSB_BIT], deviation_low_byte};
    assign band_integer = band_select[4:0];
    assign band_high = band_select[sfc_pkg::BAND_HIGH_BIT];
    assign txdr = {data_rate_high, data_rate_low};
    assign rate_scale = rate_scale_reg[sfc_pkg::RATE_SCALE_BIT];
    assign fsk_on = modulation_control_two[1];

    ////////////////////////////////////////////////////////////////////////
    // Divider arithmetic, all in fraction steps of 156.25 Hz per band factor

    // Terms given in absolute hertz shrink by the band factor in high band
    assign n_int = {2'b00, band_integer} + sfc_pkg::BAND_INT_BASE;
    assign int_units = 24'(n_int) * sfc_pkg::FRAC_MODULUS;
    assign hop_units = (24'(hop_step_size) * 24'(hop_channel_select) * 24'(sfc_pkg::HOP_UNITS)) >> band_high;
    assign off_units = {{14{fine_offset_word[9]}}, fine_offset_word};
    assign if_units = 24'(sfc_pkg::IF_UNITS) >> band_high;
    assign dev_units = (24'(deviation_word) * 24'(sfc_pkg::DEV_UNITS)) >> band_high;

    // Wrapping sums are safe: offset limits keep the total positive
    assign next_base_total = int_units + 24'(carrier_fraction) + off_units + hop_units - if_units;

    // Deviation sign follows the data bit; carrier and OOK types get none
    always_comb
    begin
        next_dev_term = 24'h000000;
        if (fsk_on)
            next_dev_term = tx_data_bit ? dev_units : 24'h000000 - dev_units;
    end

    // Recomputed every cycle, so any write lands two cycles later
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            base_total <= 24'h000000;
            dev_term <= 24'h000000;
        end
        else
        begin
            base_total <= next_base_total;
            dev_term <= next_dev_term;
        end
    end

    assign synth_total = base_total + dev_term;

    sfc_divmod u_divmod (
        .core_clk(core_clk),
        .srst(srst),
        .total(synth_total),
        .div_int(div_int),
        .div_frac(div_frac)
    );

    ////////////////////////////////////////////////////////////////////////
    // Automatic retune on hop writes during transmit

    always_ff @(posedge core_clk)
    begin
        if (srst)
            retune_req <= 1'b0;
        else
            retune_req <= wr_stb && tx_active
                && (wr_addr == sfc_pkg::ADDR_HOP_CHAN || wr_addr == sfc_pkg::ADDR_HOP_STEP);
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit bit rate generator

    // Prescaler makes the 1 MHz step from the core clock
    assign presc_wrap = presc_cnt == 5'(RATE_PRESCALE - 1);

    always_ff @(posedge core_clk)
    begin
        if (srst)
            presc_cnt <= 5'h00;
        else
            presc_cnt <= presc_wrap ? 5'h00 : presc_cnt + 5'h01;
    end

    assign rate_sum = {1'b0, rate_acc} + {6'h00, txdr};

    // Carry out of bit 16 or 21 is one bit period; scale picks which
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            rate_acc <= 21'h000000;
            bit_tick <= 1'b0;
        end
        else
        begin
            bit_tick <= 1'b0;
            if (presc_wrap)
            begin
                if (rate_scale)
                begin
                    rate_acc <= rate_sum[20:0];
                    bit_tick <= rate_sum[sfc_pkg::RATE_EXP_BASE + sfc_pkg::RATE_EXP_STEP];
                end
                else
                begin
                    rate_acc <= {5'h00, rate_sum[15:0]};
                    bit_tick <= rate_sum[sfc_pkg::RATE_EXP_BASE];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_band_clamp;
        @(posedge core_clk) disable iff (srst)
        band_integer <= sfc_pkg::BAND_INT_MAX;
    endproperty
    a_band_clamp: assert property (p_band_clamp) else $error("band integer above top band");

    property p_clamp_write;
        @(posedge core_clk) disable iff (srst)
        (wr_stb && wr_addr == sfc_pkg::ADDR_BAND && wr_data[4:0] > 5'h17) |=> band_integer == 5'h17;
    endproperty
    a_clamp_write: assert property (p_clamp_write) else $error("oversize band write not clamped");

    property p_retune;
        @(posedge core_clk) disable iff (srst)
        (wr_stb && tx_active && wr_addr == sfc_pkg::ADDR_HOP_CHAN) |=> retune_req;
    endproperty
    a_retune: assert property (p_retune) else $error("hop write in transmit gave no retune");

    property p_retune_cause;
        @(posedge core_clk) disable iff (srst)
        retune_req |-> $past(wr_stb) && $past(tx_active);
    endproperty
    a_retune_cause: assert property (p_retune_cause) else $error("retune without hop write");

    property p_carrier_only;
        @(posedge core_clk) disable iff (srst)
        (modulation_control_two[1:0] == sfc_pkg::MOD_CARRIER) |=> dev_term == 24'h000000;
    endproperty
    a_carrier_only: assert property (p_carrier_only) else $error("deviation on unmodulated carrier");

    property p_fsk_sign;
        @(posedge core_clk) disable iff (srst)
        (fsk_on && !tx_data_bit) |=> dev_term + $past(dev_units) == 24'h000000;
    endproperty
    a_fsk_sign: assert property (p_fsk_sign) else $error("zero bit did not deviate down");

    property p_tick_gap;
        @(posedge core_clk) disable iff (srst)
        bit_tick |=> !bit_tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("bit ticks too close");

    property p_nom_write;
        @(posedge core_clk) disable iff (srst)
        (wr_stb && wr_addr == sfc_pkg::ADDR_NOM_LOW) |=> ##1
            (base_total - $past(base_total)) == (24'(nominal_carrier_low) - 24'($past(nominal_carrier_low, 2)));
    endproperty
    a_nom_write: assert property (p_nom_write) else $error("carrier write not recomputed");
endmodule : sfc_freq_ctrl

/* bench/sfc_freq_ctrl_tb_top.sv */
module sfc_freq_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, srst, spi_sck, spi_nsel, spi_sdi, tx_active, tx_data_bit;
    logic spi_sdo, spi_sdo_oe, band_high, retune_req, bit_tick;
    logic [6:0] div_int;
    logic [15:0] div_frac;
    logic [7:0] sh [0:127];
    logic [7:0] rd_byte;
    logic oe_mid;
    logic [31:0] exp_q [$];
    logic [31:0] cnt_seen;
    int n_errors = 0, cmp_count = 0, cyc = 0, n_retune = 0, n_tick = 0;
    integer seed;
    int c0;
    event ev_rd, ev_div, ev_cnt;
    sfc_freq_ctrl #(.RATE_PRESCALE(20)) sfc_freq_ctrl_i (.core_clk(core_clk), .srst(srst), .spi_sck(spi_sck),
        .spi_nsel(spi_nsel), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .tx_active(tx_active),
        .tx_data_bit(tx_data_bit), .div_int(div_int), .div_frac(div_frac), .band_high(band_high),
        .retune_req(retune_req), .bit_tick(bit_tick));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Pulse counters and hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (retune_req === 1'b1) n_retune <= n_retune + 1;
        if (bit_tick === 1'b1) n_tick <= n_tick + 1;
        if (cyc == 40000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("mismatches %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask : cmp_val
    task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
        cmp_val("read data", e, g);
    endtask : cmp_rd
    task automatic cmp_div(input logic [31:0] e, input logic [31:0] g);
        cmp_val("divider", e, g);
    endtask : cmp_div
    task automatic cmp_cnt(input logic [31:0] e, input logic [31:0] g);
        cmp_val("pulse count", e, g);
    endtask : cmp_cnt
    task automatic cyc_w(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc_w
    // Expected band bit, ratio and fraction from the shadow registers
    function automatic logic [31:0] div_exp(input logic b);
        int hb, t, fd;
        hb = int'(sh[7'h75][5]);
        fd = int'({sh[7'h71][2], sh[7'h72]}) * 4;
        t = (int'(sh[7'h75][4:0]) + 24) * 64000 + int'({sh[7'h76], sh[7'h77]});
        t = t + int'($signed({sh[7'h74][1:0], sh[7'h73]}));
        t = t + ((int'(sh[7'h7a]) * int'(sh[7'h79]) * 64) >> hb) - (6000 >> hb);
        if (sh[7'h71][1]) t = b ? t + (fd >> hb) : t - (fd >> hb);
        return {8'h00, sh[7'h75][5], 7'(t / 64000), 16'(t % 64000)};
    endfunction : div_exp
    // Mode 0 frame, slow enough for the input filter; read bits taken before each rising edge
    task automatic spi_xfer(input logic [7:0] cmd, input logic [7:0] wd);
        logic [15:0] sr;
        sr = {cmd, wd};
        @(posedge core_clk) spi_nsel <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            spi_sdi <= sr[i];
            cyc_w(6);
            if (i < 8) rd_byte[i] = spi_sdo;
            if (i == 0) oe_mid = spi_sdo_oe;
            spi_sck <= 1'b1;
            cyc_w(6);
            spi_sck <= 1'b0;
        end
        cyc_w(6);
        spi_nsel <= 1'b1;
        cyc_w(8);
    endtask : spi_xfer
    // Shadow keeps only stored bits, so reads expect masks and the clamp
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        spi_xfer({1'b1, a}, d);
        if (a == sfc_pkg::ADDR_BAND) v = d & sfc_pkg::MASK_BAND;
        if (a == sfc_pkg::ADDR_BAND && v[4:0] > sfc_pkg::BAND_INT_MAX) v[4:0] = sfc_pkg::BAND_INT_MAX;
        if (a == sfc_pkg::ADDR_OFS_HIGH) v = d & sfc_pkg::MASK_OFS_HIGH;
        if (a == sfc_pkg::ADDR_RATE_SCALE) v = d & sfc_pkg::MASK_RATE_SCALE;
        if (a >= 7'h6e && a <= 7'h7a && a != 7'h78) sh[a] = v;
    endtask : wr_reg
    task automatic rd_reg(input logic [6:0] a);
        exp_q.push_back({22'h0, 2'b10, sh[a]});
        spi_xfer({1'b0, a}, 8'h00);
        -> ev_rd;
    endtask : rd_reg
    task automatic chk_div(input logic b);
        tx_data_bit <= b;
        cyc_w(6);
        exp_q.push_back(div_exp(b));
        -> ev_div;
    endtask : chk_div
    task automatic chk_cnt(input int e, input int g);
        exp_q.push_back(32'(e));
        cnt_seen = 32'(g);
        -> ev_cnt;
    endtask : chk_cnt
    ////////////////////////////////////////////////////////////////////////////////
    // Result watchers take the oldest note off the queue
    always
    begin
        @(ev_rd);
        cmp_rd(exp_q.pop_front(), {22'h0, oe_mid, spi_sdo_oe, rd_byte});
    end
    always
    begin
        @(ev_div);
        cmp_div(exp_q.pop_front(), {8'h00, band_high, div_int, div_frac});
    end
    always
    begin
        @(ev_cnt);
        cmp_cnt(exp_q.pop_front(), cnt_seen);
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        seed = 32'h9ae02557;
        srst = 1'b1;
        spi_sck = 1'b0;
        spi_nsel = 1'b1;
        spi_sdi = 1'b0;
        tx_active = 1'b0;
        tx_data_bit = 1'b0;
        for (int a = 0; a < 128; a++) sh[a] = 8'h00;
        sh[7'h6e] = sfc_pkg::RST_RATE_HIGH;
        sh[7'h6f] = sfc_pkg::RST_RATE_LOW;
        sh[7'h72] = sfc_pkg::RST_DEV_LOW;
        sh[7'h75] = sfc_pkg::RST_BAND;
        sh[7'h76] = sfc_pkg::RST_NOM_HIGH;
        sh[7'h77] = sfc_pkg::RST_NOM_LOW;
        cyc_w(2);
        srst <= 1'b0;
        cyc_w(6);
        chk_div(1'b0);
        for (int a = 'h6e; a <= 'h7a; a++) rd_reg(7'(a));
        wr_reg(7'h78, 8'h5a);
        rd_reg(7'h78);
        wr_reg(sfc_pkg::ADDR_BAND, 8'hff);
        rd_reg(sfc_pkg::ADDR_BAND);
        chk_div(1'b0);
        wr_reg(sfc_pkg::ADDR_OFS_LOW, 8'h60);
        wr_reg(sfc_pkg::ADDR_OFS_HIGH, 8'hff);
        rd_reg(sfc_pkg::ADDR_OFS_HIGH);
        chk_div(1'b0);
        wr_reg(sfc_pkg::ADDR_BAND, 8'h35);
        chk_div(1'b0);
        tx_active <= 1'b1;
        c0 = n_retune;
        wr_reg(sfc_pkg::ADDR_HOP_STEP, 8'h64);
        wr_reg(sfc_pkg::ADDR_HOP_CHAN, 8'($random(seed)));
        chk_cnt(2, n_retune - c0);
        chk_div(1'b0);
        tx_active <= 1'b0;
        c0 = n_retune;
        wr_reg(sfc_pkg::ADDR_HOP_CHAN, 8'h05);
        chk_cnt(0, n_retune - c0);
        chk_div(1'b0);
        wr_reg(sfc_pkg::ADDR_NOM_LOW, 8'($random(seed)));
        chk_div(1'b0);
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(sfc_pkg::ADDR_MOD_CTRL, 8'h04 | 8'(m));
            chk_div(1'b0);
            chk_div(1'b1);
            chk_div(1'($random(seed)));
        end
        wr_reg(sfc_pkg::ADDR_RATE_HIGH, 8'h80);
        wr_reg(sfc_pkg::ADDR_RATE_LOW, 8'h00);
        c0 = n_tick;
        cyc_w(800);
        chk_cnt(20, n_tick - c0);
        wr_reg(sfc_pkg::ADDR_RATE_SCALE, 8'hff);
        rd_reg(sfc_pkg::ADDR_RATE_SCALE);
        c0 = n_tick;
        cyc_w(2560);
        chk_cnt(2, n_tick - c0);
        cyc_w(2);
        wrap_up();
    end
endmodule : sfc_freq_ctrl_tb_top
